// File: dpod_pkg.sv
// Purpose: Shared constants and types for the divider phase offset and delay control block
// Assumes: Single fast clock domain, registers reached through a simple write/read port
// Notes:   Offsets are the printed register addresses
package dpod_pkg;

    localparam int          NUM_DIV          = 5;
    localparam int          ADDR_W           = 7;
    localparam int          DATA_W           = 8;

    localparam logic [6:0]  ADDR_DLY_FS      = 7'h35;
    localparam logic [6:0]  ADDR_DLY_FINE    = 7'h36;
    localparam logic [6:0]  ADDR_DLY_FS_ALT  = 7'h39;
    localparam logic [6:0]  ADDR_DLY_FINE_ALT = 7'h3A;
    localparam logic [6:0]  ADDR_DIV0_PHASE  = 7'h4B;
    localparam logic [6:0]  ADDR_DIV4_PHASE  = 7'h53;
    localparam logic [6:0]  ADDR_DIV_RATIO0  = 7'h4A;
    localparam logic [6:0]  ADDR_OUT_ENABLE  = 7'h3C;
    localparam logic [6:0]  ADDR_SYNC_CTRL   = 7'h58;

    localparam int          PH_OFS_LSB       = 0;
    localparam int          PH_OFS_MSB       = 3;
    localparam int          PH_START_BIT     = 4;
    localparam int          SOFT_SYNC_BIT    = 2;
    localparam int          FUNC_SEL_LSB     = 5;
    localparam int          FUNC_SEL_MSB     = 6;
    localparam logic [1:0]  FUNC_SEL_SYNC    = 2'h1;
    localparam int          RAMP_I_MSB       = 2;
    localparam int          RAMP_CAP_LSB     = 3;
    localparam int          RAMP_CAP_MSB     = 5;
    localparam int          FINE_LSB         = 1;
    localparam int          FINE_MSB         = 5;

    localparam logic [7:0]  RST_PHASE        = 8'h00;
    localparam logic [7:0]  RST_DLY          = 8'h00;
    localparam logic [7:0]  RST_RATIO        = 8'h11;
    localparam logic [7:0]  RST_OUT_ENABLE   = 8'h1F;
    localparam logic [7:0]  RST_SYNC_CTRL    = 8'h00;
    localparam int          HALF_W           = 4;
    localparam int          WAIT_W           = 5;
    localparam int          START_WEIGHT     = 16;

    typedef struct packed {
        logic              wr_en;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } dpod_reg_req_t;

    typedef struct packed {
        logic [HALF_W-1:0] hi_cycles;
        logic [HALF_W-1:0] lo_cycles;
        logic [HALF_W-1:0] phase_ofs;
        logic              start_high;
        logic              enable;
    } dpod_div_cfg_t;

    typedef enum logic [1:0] {
        DPOD_HOLD = 2'b00,
        DPOD_WAIT = 2'b01,
        DPOD_RUN  = 2'b10,
        DPOD_OFF  = 2'b11
    } dpod_div_state_t;

endpackage

// File: dpod_divider.sv
// Purpose: One output divider with phase-wait start after synchronization
// Assumes: Runs on the selected fast clock; sync_i is a level from the top
// Notes:   Output registered; off outputs sit low
`timescale 1ns/1ns
module dpod_divider
    import dpod_pkg::*;
(
    input  wire logic          clk_i,
    input  wire logic          rst_b_i,
    input  wire logic          sync_i,
    input  wire dpod_div_cfg_t cfg_i,
    output logic               clk_o
);

    dpod_div_state_t   state_q;
    logic [WAIT_W-1:0] wait_q;
    logic [HALF_W-1:0] cnt_q;
    logic [WAIT_W-1:0] wait_target;

    // Start bit adds sixteen edges to the wait
    assign wait_target = {cfg_i.start_high, cfg_i.phase_ofs};

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            state_q <= DPOD_HOLD;
            wait_q  <= '0;
            cnt_q   <= '0;
            clk_o   <= 1'b0;
        end else if (!cfg_i.enable) begin
            state_q <= DPOD_OFF;
            wait_q  <= '0;
            cnt_q   <= '0;
            clk_o   <= 1'b0;
        end else if (sync_i || state_q == DPOD_OFF) begin
            state_q <= DPOD_HOLD;
            wait_q  <= '0;
            cnt_q   <= '0;
            clk_o   <= cfg_i.start_high;
        end else begin
            case (state_q)
                DPOD_HOLD: begin
                    state_q <= DPOD_WAIT;
                    wait_q  <= '0;
                end
                DPOD_WAIT: begin
                    // Offsets past the ratio simply delay by whole periods, so phases repeat
                    if (wait_q >= wait_target) begin
                        state_q <= DPOD_RUN;
                        clk_o   <= ~clk_o;
                        cnt_q   <= '0;
                    end else begin
                        wait_q <= wait_q + 1'b1;
                    end
                end
                DPOD_RUN: begin
                    // One fast-clock step per phase unit; ratio sets distinct phases
                    if (cnt_q >= (clk_o ? cfg_i.hi_cycles : cfg_i.lo_cycles)) begin
                        clk_o <= ~clk_o;
                        cnt_q <= '0;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end
                default: begin
                    state_q <= DPOD_HOLD;
                end
            endcase
        end
    end

endmodule

// File: dpod_top.sv
// Purpose: Phase offset, output enable, sync and delay control for five dividers
// Assumes: Register port is synchronous to the fast clock; sync pin low-active
// Notes:   Delay fields drive the analog delay directly; no timing in logic
`timescale 1ns/1ns

module dpod_top
    import dpod_pkg::*;
#(
    parameter int N_DIV = NUM_DIV
) (
    input  wire logic                clk_i,
    input  wire logic                rst_b_i,
    input  wire logic                hw_sync_low_i,
    input  wire dpod_reg_req_t       reg_req_i,
    output logic [DATA_W-1:0]        rdata_o,
    output logic [N_DIV-1:0]         div_clk_o,
    output logic [RAMP_I_MSB:0]      ramp_current_o,
    output logic [2:0]               ramp_caps_o,
    output logic [FINE_MSB-FINE_LSB:0] fine_adjust_o,
    output logic [RAMP_I_MSB:0]      ramp_current_alt_o,
    output logic [2:0]               ramp_caps_alt_o,
    output logic [FINE_MSB-FINE_LSB:0] fine_adjust_alt_o
);

    logic [DATA_W-1:0] phase_q   [N_DIV];
    logic [DATA_W-1:0] ratio_q   [N_DIV];
    logic [DATA_W-1:0] dly_fs_q;
    logic [DATA_W-1:0] dly_fine_q;
    logic [DATA_W-1:0] dly_fs_alt_q;
    logic [DATA_W-1:0] dly_fine_alt_q;
    logic [DATA_W-1:0] out_en_q;
    logic [DATA_W-1:0] sync_ctrl_q;
    logic [DATA_W-1:0] rdata_d;
    logic              sync_q;
    logic [N_DIV-1:0]  div_clk;

    // One process per register keeps each write decode on its own
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dly_fs_q <= RST_DLY;
        end else if (reg_req_i.wr_en && reg_req_i.addr == ADDR_DLY_FS) begin
            dly_fs_q <= reg_req_i.wdata;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dly_fine_q <= RST_DLY;
        end else if (reg_req_i.wr_en && reg_req_i.addr == ADDR_DLY_FINE) begin
            dly_fine_q <= reg_req_i.wdata;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dly_fs_alt_q <= RST_DLY;
        end else if (reg_req_i.wr_en && reg_req_i.addr == ADDR_DLY_FS_ALT) begin
            dly_fs_alt_q <= reg_req_i.wdata;
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dly_fine_alt_q <= RST_DLY;
        end else if (reg_req_i.wr_en && reg_req_i.addr == ADDR_DLY_FINE_ALT) begin
            dly_fine_alt_q <= reg_req_i.wdata;
        end
    end

    // Enable bits reach the dividers on the next edge
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            out_en_q <= RST_OUT_ENABLE;
        end else if (reg_req_i.wr_en && reg_req_i.addr == ADDR_OUT_ENABLE) begin
            out_en_q <= reg_req_i.wdata;
        end
    end

    // Soft sync and pin function share one control register
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sync_ctrl_q <= RST_SYNC_CTRL;
        end else if (reg_req_i.wr_en && reg_req_i.addr == ADDR_SYNC_CTRL) begin
            sync_ctrl_q <= reg_req_i.wdata;
        end
    end

    // Per-divider phase and ratio registers
    genvar g;
    generate
        for (g = 0; g < N_DIV; g++) begin : g_div
            localparam logic [ADDR_W-1:0] PH_ADDR = ADDR_DIV0_PHASE + ADDR_W'(2 * g);
            localparam logic [ADDR_W-1:0] RT_ADDR = ADDR_DIV_RATIO0 + ADDR_W'(2 * g);
            dpod_div_cfg_t cfg;

            always_ff @(posedge clk_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    phase_q[g] <= RST_PHASE;
                end else if (reg_req_i.wr_en && reg_req_i.addr == PH_ADDR) begin
                    phase_q[g] <= reg_req_i.wdata;
                end
            end

            // Ratio sits beside the phase so each divider's setup stays local
            always_ff @(posedge clk_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    ratio_q[g] <= RST_RATIO;
                end else if (reg_req_i.wr_en && reg_req_i.addr == RT_ADDR) begin
                    ratio_q[g] <= reg_req_i.wdata;
                end
            end

            assign cfg.lo_cycles  = ratio_q[g][7:4];
            assign cfg.hi_cycles  = ratio_q[g][3:0];
            assign cfg.phase_ofs  = phase_q[g][PH_OFS_MSB:PH_OFS_LSB];
            assign cfg.start_high = phase_q[g][PH_START_BIT];
            assign cfg.enable     = out_en_q[g];

            dpod_divider u_div (
                .clk_i   (clk_i),
                .rst_b_i (rst_b_i),
                .sync_i  (sync_q),
                .cfg_i   (cfg),
                .clk_o   (div_clk[g])
            );
        end
    endgenerate

    // Pin sync only counts when the function pin is set to sync mode
    // Registered once so both sync sources reach every divider together
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            sync_q <= 1'b1;
        end else begin
            sync_q <= sync_ctrl_q[SOFT_SYNC_BIT]
                || (sync_ctrl_q[FUNC_SEL_MSB:FUNC_SEL_LSB] == FUNC_SEL_SYNC
                    && !hw_sync_low_i);
        end
    end

    // Read mux; unmapped addresses read as zero
    always_comb begin
        rdata_d = '0;
        if (reg_req_i.addr == ADDR_DLY_FS) begin
            rdata_d = dly_fs_q;
        end else if (reg_req_i.addr == ADDR_DLY_FINE) begin
            rdata_d = dly_fine_q;
        end else if (reg_req_i.addr == ADDR_DLY_FS_ALT) begin
            rdata_d = dly_fs_alt_q;
        end else if (reg_req_i.addr == ADDR_DLY_FINE_ALT) begin
            rdata_d = dly_fine_alt_q;
        end else if (reg_req_i.addr == ADDR_OUT_ENABLE) begin
            rdata_d = out_en_q;
        end else if (reg_req_i.addr == ADDR_SYNC_CTRL) begin
            rdata_d = sync_ctrl_q;
        end else begin
            for (int i = 0; i < N_DIV; i++) begin
                if (reg_req_i.addr == ADDR_DIV0_PHASE + ADDR_W'(2 * i)) begin
                    rdata_d = phase_q[i];
                end else if (reg_req_i.addr == ADDR_DIV_RATIO0 + ADDR_W'(2 * i)) begin
                    rdata_d = ratio_q[i];
                end
            end
        end
    end

    // Read data leaves from a flop one cycle after the address
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rdata_o <= '0;
        end else begin
            rdata_o <= rdata_d;
        end
    end

    // Costs one cycle of latency, but the pins never see divider glitches
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            div_clk_o <= '0;
        end else begin
            div_clk_o <= div_clk;
        end
    end

    // Delay fields pass raw; the analog ramp decodes them
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ramp_current_o <= '0;
            ramp_caps_o    <= '0;
            fine_adjust_o  <= '0;
        end else begin
            ramp_current_o <= dly_fs_q[RAMP_I_MSB:0];
            ramp_caps_o    <= dly_fs_q[RAMP_CAP_MSB:RAMP_CAP_LSB];
            fine_adjust_o  <= dly_fine_q[FINE_MSB:FINE_LSB];
        end
    end

    // Alternate set mirrors the primary field layout
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ramp_current_alt_o <= '0;
            ramp_caps_alt_o    <= '0;
            fine_adjust_alt_o  <= '0;
        end else begin
            ramp_current_alt_o <= dly_fs_alt_q[RAMP_I_MSB:0];
            ramp_caps_alt_o    <= dly_fs_alt_q[RAMP_CAP_MSB:RAMP_CAP_LSB];
            fine_adjust_alt_o  <= dly_fine_alt_q[FINE_MSB:FINE_LSB];
        end
    end

endmodule

// File: dpod_top_props.sv
// Purpose: Port-level checks for the phase offset and delay control block
// Assumes: Single clock domain, register port one write per cycle
// Notes:   Sync and enable checks need idle cycles after the write
`timescale 1ns/1ns
module dpod_top_props
    import dpod_pkg::*;
#(
    parameter int N_DIV = NUM_DIV
) (
    input wire logic                     clk_i,
    input wire logic                     rst_b_i,
    input wire logic                     hw_sync_low_i,
    input wire dpod_reg_req_t            reg_req_i,
    input wire logic [DATA_W-1:0]        rdata_o,
    input wire logic [N_DIV-1:0]         div_clk_o,
    input wire logic [RAMP_I_MSB:0]      ramp_current_o,
    input wire logic [2:0]               ramp_caps_o,
    input wire logic [FINE_MSB-FINE_LSB:0] fine_adjust_o,
    input wire logic [RAMP_I_MSB:0]      ramp_current_alt_o,
    input wire logic [2:0]               ramp_caps_alt_o,
    input wire logic [FINE_MSB-FINE_LSB:0] fine_adjust_alt_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_wr(logic [6:0] a);
        reg_req_i.wr_en && reg_req_i.addr == a;
    endsequence
    sequence s_idle2;
        !reg_req_i.wr_en [*2];
    endsequence
    property p_cur;
        s_wr(ADDR_DLY_FS) ##1 s_idle2 |=> ramp_current_o == $past(reg_req_i.wdata[2:0], 3);
    endproperty
    a_cur: assert property (p_cur) else $error("ramp current field wrong");
    property p_caps_alt;
        s_wr(ADDR_DLY_FS_ALT) ##1 s_idle2 |=> ramp_caps_alt_o == $past(reg_req_i.wdata[5:3], 3);
    endproperty
    a_caps_alt: assert property (p_caps_alt) else $error("alt capacitor field wrong");
    property p_fine;
        s_wr(ADDR_DLY_FINE) ##1 s_idle2 |=> fine_adjust_o == $past(reg_req_i.wdata[5:1], 3);
    endproperty
    a_fine: assert property (p_fine) else $error("fine adjust field wrong");
    property p_fine_alt;
        s_wr(ADDR_DLY_FINE_ALT) ##1 s_idle2 |=> fine_adjust_alt_o == $past(reg_req_i.wdata[5:1], 3);
    endproperty
    a_fine_alt: assert property (p_fine_alt) else $error("alt fine field wrong");
    property p_rdback;
        s_wr(ADDR_DIV0_PHASE) ##1 (!reg_req_i.wr_en && reg_req_i.addr == ADDR_DIV0_PHASE)
            |=> rdata_o[4:0] == $past(reg_req_i.wdata[4:0], 2);
    endproperty
    a_rdback: assert property (p_rdback) else $error("phase readback wrong");
    property p_unmapped;
        !reg_req_i.wr_en && reg_req_i.addr == 7'h00 |=> rdata_o == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    // Write-free window: a start-bit write would legally move a held output
    property p_hold;
        reg_req_i.wr_en && reg_req_i.addr == ADDR_SYNC_CTRL && reg_req_i.wdata[SOFT_SYNC_BIT]
            ##1 !reg_req_i.wr_en [*6] |-> $stable(div_clk_o);
    endproperty
    a_hold: assert property (p_hold) else $error("outputs moved under soft sync");
    property p_off;
        reg_req_i.wr_en && reg_req_i.addr == ADDR_OUT_ENABLE && !reg_req_i.wdata[0]
            ##1 !reg_req_i.wr_en [*4] |-> !div_clk_o[0];
    endproperty
    a_off: assert property (p_off) else $error("disabled output not low");
endmodule

bind dpod_top dpod_top_props #(.N_DIV(N_DIV)) i_dpod_top_props (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .hw_sync_low_i(hw_sync_low_i), .reg_req_i(reg_req_i),
    .rdata_o(rdata_o), .div_clk_o(div_clk_o), .ramp_current_o(ramp_current_o),
    .ramp_caps_o(ramp_caps_o), .fine_adjust_o(fine_adjust_o),
    .ramp_current_alt_o(ramp_current_alt_o), .ramp_caps_alt_o(ramp_caps_alt_o),
    .fine_adjust_alt_o(fine_adjust_alt_o));

// File: divider_phase_offset_and_delay_ctrl_test.sv
// Purpose: Self-checking bench for phase offsets, sync, enables and delay fields
// Assumes: Ratio 0x11 gives divide by four; start levels read from phase bit 4
// Notes:   Edge timing checked relative to output 0, not to the write
`timescale 1ns/1ns
module divider_phase_offset_and_delay_ctrl_test;
    import dpod_pkg::*;
    logic          clk_i, rst_b_i, hw_sync_low_i;
    dpod_reg_req_t reg_req_i;
    logic [7:0]    rdata_o;
    logic [4:0]    div_clk_o, fine_o, fine_alt_o;
    logic [2:0]    cur_o, caps_o, cur_alt_o, caps_alt_o;
    int            err_count, checks_done;

    dpod_top i_dpod_top (.clk_i(clk_i), .rst_b_i(rst_b_i), .hw_sync_low_i(hw_sync_low_i),
        .reg_req_i(reg_req_i), .rdata_o(rdata_o), .div_clk_o(div_clk_o),
        .ramp_current_o(cur_o), .ramp_caps_o(caps_o), .fine_adjust_o(fine_o),
        .ramp_current_alt_o(cur_alt_o), .ramp_caps_alt_o(caps_alt_o),
        .fine_adjust_alt_o(fine_alt_o));

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(posedge clk_i);
        reg_req_i <= '{1'b1, a, d};
        @(posedge clk_i);
        reg_req_i.wr_en <= 1'b0;
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        @(posedge clk_i);
        reg_req_i <= '{1'b0, a, 8'h00};
        @(posedge clk_i);
        #1;
        check(rdata_o, exp);
    endtask
    // Counts highs of output 0 and toggles of output 1 over twelve cycles
    task automatic watch(output int hi0, output int tog1);
        logic prev;
        hi0 = 0;
        tog1 = 0;
        prev = div_clk_o[1];
        repeat (12) begin
            @(posedge clk_i);
            #1;
            hi0 += int'(div_clk_o[0] !== 1'b0);
            tog1 += int'(div_clk_o[1] !== prev);
            prev = div_clk_o[1];
        end
    endtask
    task automatic test_regs;
        for (int n = 0; n < NUM_DIV; n++) begin
            wr(ADDR_DIV0_PHASE + 7'(2 * n), 8'h10 + 8'(3 * n));
            rd(ADDR_DIV0_PHASE + 7'(2 * n), 8'h10 + 8'(3 * n));
        end
        wr(ADDR_DLY_FS, 8'h2D);
        rd(ADDR_DLY_FS, 8'h2D);
        check(8'(cur_o), 8'h05);
        check(8'(caps_o), 8'h05);
        wr(ADDR_DLY_FINE, 8'h3E);
        rd(ADDR_DLY_FINE, 8'h3E);
        check(8'(fine_o), 8'h1F);
        wr(ADDR_DLY_FS_ALT, 8'h1A);
        rd(ADDR_DLY_FS_ALT, 8'h1A);
        check({2'b00, caps_alt_o, cur_alt_o}, 8'h1A);
        wr(ADDR_DLY_FINE_ALT, 8'h02);
        rd(ADDR_DLY_FINE_ALT, 8'h02);
        check(8'(fine_alt_o), 8'h01);
        wr(7'h00, 8'hA5);
        rd(7'h00, 8'h00);
    endtask
    task automatic test_phase;
        logic [7:0] ph[NUM_DIV] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h10};
        int         first[NUM_DIV];
        int         fall0;
        for (int n = 0; n < NUM_DIV; n++) begin
            wr(ADDR_DIV_RATIO0 + 7'(2 * n), RST_RATIO);
            wr(ADDR_DIV0_PHASE + 7'(2 * n), ph[n]);
            first[n] = -1;
        end
        wr(ADDR_SYNC_CTRL, 8'h04);
        repeat (7) @(posedge clk_i);
        #1;
        check(8'(div_clk_o), 8'h10);
        wr(ADDR_SYNC_CTRL, 8'h00);
        fall0 = -1;
        for (int c = 0; c < 40; c++) begin
            @(posedge clk_i);
            #1;
            for (int n = 0; n < NUM_DIV; n++)
                if (first[n] < 0 && div_clk_o[n] !== ph[n][4]) first[n] = c;
            if (first[0] >= 0 && fall0 < 0 && div_clk_o[0] === 1'b0) fall0 = c;
        end
        check(8'(first[0] >= 0 && first[0] < 8), 8'h01);
        for (int n = 1; n < NUM_DIV; n++)
            check(8'(first[n] - first[0]), 8'(ph[n][3:0]) + 8'(16 * ph[n][4]));
        check(8'(fall0 - first[0]), 8'h02);
        check(8'(div_clk_o[3]), 8'(div_clk_o[0]));
    endtask
    task automatic test_enable_hw;
        int hi0, tog1;
        wr(ADDR_OUT_ENABLE, 8'h1E);
        repeat (5) @(posedge clk_i);
        watch(hi0, tog1);
        check(8'(hi0), 8'h00);
        check(8'(tog1 > 0), 8'h01);
        @(posedge clk_i);
        hw_sync_low_i <= 1'b0;
        watch(hi0, tog1);
        check(8'(tog1 > 0), 8'h01);
        wr(ADDR_SYNC_CTRL, 8'h20);
        repeat (6) @(posedge clk_i);
        #1;
        check(8'(div_clk_o), 8'h10);
        @(posedge clk_i);
        hw_sync_low_i <= 1'b1;
        watch(hi0, tog1);
        check(8'(tog1 > 0), 8'h01);
    endtask
    task automatic end_of_test;
        $display("checks_done=%0d err_count=%0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    initial begin
        repeat (3000) @(posedge clk_i);
        err_count++;
        end_of_test();
    end
    initial begin
        rst_b_i = 1'b0;
        hw_sync_low_i = 1'b1;
        reg_req_i = '0;
        err_count = 0;
        checks_done = 0;
        repeat (4) @(posedge clk_i);
        rst_b_i <= 1'b1;
        test_regs();
        test_phase();
        test_enable_hw();
        end_of_test();
    end
endmodule
